/* shared/rcfg_cfg.svh */
// Purpose: constants of the receiver configuration register bank
// Assumes: 10 MHz sys_clk; frame bits arrive one per data-line window
// Notes: frame bit n (1..15) sits at shift position 15-n after capture
// Notes on behaviour
// [RQ1] two 12-bit volatile registers, both written over the data line
// [RQ2] power-on reset loads both registers with their default fields
// [RQ3] after a reset the data line shows the reset marker square wave
// [RQ4] controller reprograms registers after seeing the reset marker
// [RQ5] frame bit 1 high is an off command; no register written
// [RQ6] bit 1 low: bit 2 high selects operating, low selects limits register
// [RQ7] payload committed only when stop bit 15 is 0
// [RQ8] controller always sends stop bit as 0; the bench also sends a stop bit of 1 in t_refused
// [RQ9] operating layout: baud, bit-check, modulation, sleep, extension, noise
// [RQ10] baud band 00/01/10/11 gives limit scale 8/4/2/1
// [RQ11] bit-check code 00/01/10/11 gives 0/3/6/9 bits
// [RQ12] modulation bit 0 is FSK, 1 is ASK
// [RQ13] sleep time is count times extension times 1024 clock periods
// [RQ14] sleep count 0 means continuous polling
// [RQ15] sleep count 31 means permanent sleep; default count 6
// [RQ16] sleep extension bit selects multiplier 1 or 8
// [RQ17] limits: bits 3-8 lower limit, 9-14 upper limit, MSB first
// [RQ18] noise bit 1 enables noise suppression, the default
// [RQ19] limits default lower 21, upper 41
// [RQ20] each frame bit in its own window; low sends 0, high sends 1
// [RQ21] frame shifted in whole, register updated atomically after stop check
`ifndef RCFG_CFG_SVH
`define RCFG_CFG_SVH
`define FRAME_BITS 15
`define REG_BITS 12
`define OPER_RESET 12'h119
`define LIMIT_RESET 12'h569
`define SLEEP_UNIT 1024
`define SLEEP_FOREVER 5'h1f
`define RM_HALF_CYCLES 5000
`endif

/* shared/rcfg_pkg.sv */
// Purpose: types of the receiver configuration register bank
// Assumes: nothing beyond the constants header
// Notes: field order follows frame order, MSB first
package rcfg_pkg;
   typedef struct packed {
      logic [1:0] baud_band_select;
      logic [1:0] check_code;
      logic modulation_select;
      logic [4:0] sleep_count;
      logic sleep_ext;
      logic noise_enable;
   } oper_cfg_s;
   typedef struct packed {
      logic [5:0] lim_lower;
      logic [5:0] lim_upper;
   } limit_cfg_s;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_SHIFT = 3'b010,
      ST_COMMIT = 3'b100
   } frame_state_e;
endpackage

/* rtl/reset_marker_gen.sv */
// Purpose: square wave shown on the data line while the reset marker stands
// Assumes: half period is far longer than any data edge spacing
// Notes: output only low-drives; high phase is released line
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_cfg.svh"
module reset_marker_gen #(
   parameter int HALF_CYCLES = `RM_HALF_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // control
   input wire logic active,
   // pattern
   output logic wave_low
);
   logic [15:0] cnt_ff, nxt_cnt;
   logic phase_ff, nxt_phase;
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_phase = phase_ff;
      if (!active) begin
         nxt_cnt = 16'h0000;
         nxt_phase = 1'b0;
      end else if (cnt_ff == 16'(HALF_CYCLES - 1)) begin
         nxt_cnt = 16'h0000;
         nxt_phase = ~phase_ff;
      end else begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= 16'h0000;
         phase_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         phase_ff <= nxt_phase;
      end
   end
   assign wave_low = active & phase_ff;
endmodule // reset_marker_gen
`default_nettype wire

/* rtl/receiver_config_registers.sv */
// Purpose: configuration store, frame capture and decoded settings
// Assumes: frame bits come as bit_valid pulses with bit_value, frame_start first
// Notes: window timing and frame-bit sampling live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "rcfg_cfg.svh"
module receiver_config_registers
   import rcfg_pkg::*;
#(
   parameter int RM_HALF = `RM_HALF_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // decoded frame bits from the window logic
   input wire logic frame_start,
   input wire logic bit_valid,
   input wire logic bit_value,
   // data line, open drain
   input wire logic data_in,
   output logic data_out,
   output logic data_oe,
   // settings
   output oper_cfg_s oper_cfg,
   output limit_cfg_s limit_cfg,
   output logic [3:0] limit_scale,
   output logic [3:0] check_bits,
   output logic [7:0] sleep_mult,
   output logic poll_continuous,
   output logic sleep_forever,
   output logic off_cmd,
   output logic write_done,
   output logic reset_marker
);
   // scale factor per baud band code
   function automatic logic [3:0] scale_of(input logic [1:0] code);
      case (code)
         2'b00: scale_of = 4'h8;
         2'b01: scale_of = 4'h4;
         2'b10: scale_of = 4'h2;
         default: scale_of = 4'h1;
      endcase
   endfunction

   // bits checked per bit-check code: 0, 3, 6 or 9
   function automatic logic [3:0] checks_of(input logic [1:0] code);
      case (code)
         2'b00: checks_of = 4'h0;
         2'b01: checks_of = 4'h3;
         2'b10: checks_of = 4'h6;
         default: checks_of = 4'h9;
      endcase
   endfunction

   // sleep extension factor; sleep time = count * factor * sleep unit clocks
   function automatic logic [7:0] mult_of(input logic ext);
      mult_of = ext ? 8'h08 : 8'h01;
   endfunction

   // frame bit n (1..15) of a captured frame; bit 1 was shifted in first
   function automatic logic frame_bit(input logic [14:0] f, input int n);
      frame_bit = f[`FRAME_BITS - n];
   endfunction

   // off command: bit 1 high, the rest of the frame is ignored
   function automatic logic is_off(input logic [14:0] f);
      is_off = frame_bit(f, 1);
   endfunction

   // write only with bit 1 low and the stop bit low
   function automatic logic is_write(input logic [14:0] f);
      is_write = !frame_bit(f, 1) && !frame_bit(f, `FRAME_BITS);
   endfunction

   // bit 2 is the register address: high picks the operating register
   function automatic logic to_oper(input logic [14:0] f);
      to_oper = frame_bit(f, 2);
   endfunction

   // payload is frame bits 3..14; bit 3 lands in the register msb
   function automatic logic [11:0] payload_of(input logic [14:0] f);
      payload_of = f[`REG_BITS:1];
   endfunction

   // an outside low counts only while this side is not pulling the line
   function automatic logic line_pulled(input logic line, input logic own_low);
      line_pulled = !line && !own_low;
   endfunction

   frame_state_e st_ff, nxt_st;
   logic [14:0] shift_ff, nxt_shift;
   logic [3:0] cnt_ff, nxt_cnt;
   logic [11:0] oper_ff, nxt_oper;
   logic [11:0] limit_ff, nxt_limit;
   logic off_ff, nxt_off;
   logic done_ff, nxt_done;
   logic rm_ff, nxt_rm;
   logic rm_low;
   logic data_in_ff, nxt_data_in;
   logic data_low_ff, nxt_data_low;
   logic data_low_d_ff, nxt_data_low_d;
   oper_cfg_s oper_v;
   limit_cfg_s limit_v;
   oper_cfg_s nxt_oper_cfg;
   limit_cfg_s nxt_limit_cfg;
   logic [3:0] nxt_scale, nxt_checks;
   logic [7:0] nxt_mult;
   logic nxt_poll, nxt_forever;

   // frame capture: fifteen bits into the holding register
   always_comb begin
      nxt_st = st_ff;
      nxt_shift = shift_ff;
      nxt_cnt = cnt_ff;
      case (st_ff)
         ST_IDLE: begin
            // bits before a frame start belong to no frame
            if (frame_start) begin
               nxt_st = ST_SHIFT;
               nxt_cnt = 4'h0;
            end
         end
         ST_SHIFT: begin
            // a second frame start here is ignored; the frame runs to its end
            if (bit_valid) begin
               nxt_shift = {shift_ff[13:0], bit_value}; // see [RQ20] [RQ21]
               nxt_cnt = cnt_ff + 4'h1;
               if (cnt_ff == 4'(`FRAME_BITS - 1)) begin
                  nxt_st = ST_COMMIT;
               end
            end
         end
         ST_COMMIT: begin
            nxt_st = ST_IDLE;
         end
         default: begin
            nxt_st = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= ST_IDLE;
         shift_ff <= 15'h0000;
         cnt_ff <= 4'h0;
      end else begin
         st_ff <= nxt_st;
         shift_ff <= nxt_shift;
         cnt_ff <= nxt_cnt;
      end
   end

   // configuration store: changes only in the commit cycle, so a cut or
   // refused frame never leaves a half-written register behind
   always_comb begin
      nxt_oper = oper_ff;
      nxt_limit = limit_ff;
      nxt_off = 1'b0;
      nxt_done = 1'b0;
      if (st_ff == ST_COMMIT) begin
         if (is_off(shift_ff)) begin
            nxt_off = 1'b1; // see [RQ5]
         end else if (is_write(shift_ff)) begin // see [RQ7] [RQ21]
            nxt_done = 1'b1;
            if (to_oper(shift_ff)) begin
               nxt_oper = payload_of(shift_ff); // see [RQ6] [RQ9]
            end else begin
               nxt_limit = payload_of(shift_ff); // see [RQ6] [RQ17]
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         oper_ff <= `OPER_RESET; // see [RQ1] [RQ2]
         limit_ff <= `LIMIT_RESET; // see [RQ2] [RQ19]
         off_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         oper_ff <= nxt_oper;
         limit_ff <= nxt_limit;
         off_ff <= nxt_off;
         done_ff <= nxt_done;
      end
   end

   // line sampling: the sampled line lags the drive by one flop, so the
   // own drive is delayed once more before the two are compared
   always_comb begin
      nxt_data_in = data_in;
      nxt_data_low = rm_low;
      nxt_data_low_d = data_low_ff;
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         data_in_ff <= 1'b1;
         data_low_ff <= 1'b0;
         data_low_d_ff <= 1'b0;
      end else begin
         data_in_ff <= nxt_data_in;
         data_low_ff <= nxt_data_low;
         data_low_d_ff <= nxt_data_low_d;
      end
   end

   // marker stands from reset until a frame start or until the controller pulls the line low;
   // own low phases must never cancel it
   always_comb begin
      nxt_rm = rm_ff;
      if (frame_start || line_pulled(data_in_ff, data_low_d_ff)) begin
         nxt_rm = 1'b0; // see [RQ3]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rm_ff <= 1'b1; // see [RQ3]
      end else begin
         rm_ff <= nxt_rm;
      end
   end

   reset_marker_gen #(
      .HALF_CYCLES(RM_HALF)
   ) u_rm (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .active(rm_ff),
      .wave_low(rm_low)
   );

   // decoded settings registered so every output but the tied-low data_out comes from a flip-flop;
   // they follow the raw register by one clock
   always_comb begin
      oper_v = oper_cfg_s'(oper_ff);
      limit_v = limit_cfg_s'(limit_ff);
      nxt_oper_cfg = oper_v; // see [RQ12] [RQ18]
      nxt_limit_cfg = limit_v;
      nxt_scale = scale_of(oper_v.baud_band_select); // see [RQ10]
      nxt_checks = checks_of(oper_v.check_code); // see [RQ11]
      nxt_mult = mult_of(oper_v.sleep_ext); // see [RQ13] [RQ16]
      nxt_poll = (oper_v.sleep_count == 5'h00); // see [RQ14]
      nxt_forever = (oper_v.sleep_count == `SLEEP_FOREVER); // see [RQ15]
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         oper_cfg <= oper_cfg_s'(`OPER_RESET);
         limit_cfg <= limit_cfg_s'(`LIMIT_RESET);
         limit_scale <= 4'h8;
         check_bits <= 4'h3;
         sleep_mult <= 8'h01;
         poll_continuous <= 1'b0;
         sleep_forever <= 1'b0;
      end else begin
         oper_cfg <= nxt_oper_cfg;
         limit_cfg <= nxt_limit_cfg;
         limit_scale <= nxt_scale;
         check_bits <= nxt_checks;
         sleep_mult <= nxt_mult;
         poll_continuous <= nxt_poll;
         sleep_forever <= nxt_forever;
      end
   end

   assign data_out = 1'b0;
   assign data_oe = data_low_ff; // see [RQ3]
   assign off_cmd = off_ff;
   assign write_done = done_ff;
   assign reset_marker = rm_ff;
endmodule // receiver_config_registers
`default_nettype wire

/* dv/rcfg_props.sv */
// Purpose: port checks of the config register bank
// Assumes: all decoded outputs are registered together in one clock
// Notes: bound into the design top
`timescale 1ns/1ps
`default_nettype none
module rcfg_props
   import rcfg_pkg::*;
#(
   parameter int RM_HALF = 4
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // observed
   input wire logic data_out,
   input wire logic data_oe,
   input wire oper_cfg_s oper_cfg,
   input wire limit_cfg_s limit_cfg,
   input wire logic [3:0] limit_scale,
   input wire logic [3:0] check_bits,
   input wire logic [7:0] sleep_mult,
   input wire logic poll_continuous,
   input wire logic sleep_forever,
   input wire logic off_cmd,
   input wire logic write_done
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   a_scale_map: assert property (
      limit_scale == (4'h8 >> oper_cfg.baud_band_select)) else $error("scale map");
   a_check_map: assert property (
      check_bits == {2'h0, oper_cfg.check_code} * 4'h3) else $error("check map");
   a_mult_map: assert property (
      sleep_mult == (oper_cfg.sleep_ext ? 8'h08 : 8'h01)) else $error("mult map");
   a_poll_zero: assert property (
      poll_continuous == (oper_cfg.sleep_count == 5'h00)) else $error("poll flag");
   a_sleep_forever: assert property (
      sleep_forever == (oper_cfg.sleep_count == 5'h1f)) else $error("sleep flag");
   a_pulse_excl: assert property (!(write_done && off_cmd))
      else $error("both pulses");
   a_cfg_hold: assert property (
      ($changed(oper_cfg) || $changed(limit_cfg)) |-> $past(write_done))
      else $error("cfg change");
   a_open_drain: assert property (data_oe |-> !data_out)
      else $error("drives high");
endmodule // rcfg_props
bind receiver_config_registers rcfg_props #(.RM_HALF(RM_HALF)) i_rcfg_props (.*);
`default_nettype wire

/* dv/mcu_model.sv */
// Purpose: controller side, sends frames and pulls the data line
// Assumes: one frame bit per clock after frame start
// Notes: bit value inverts once the last frame bit is taken
`timescale 1ns/1ps
`default_nettype none
module mcu_model (
   // clock
   input wire logic sys_clk,
   // frame and line
   output logic frame_start,
   output logic bit_valid,
   output logic bit_value,
   output logic pull_low
);
   initial {frame_start, bit_valid, bit_value, pull_low} = 4'h0;
   task automatic send(input logic [14:0] f);
      @(posedge sys_clk) frame_start <= 1'b1;
      for (int i = 14; i >= 0; i--) begin
         @(posedge sys_clk) frame_start <= 1'b0;
         bit_valid <= 1'b1;
         bit_value <= f[i];
      end
      @(posedge sys_clk) bit_valid <= 1'b0;
      bit_value <= ~f[0];
   endtask
   task automatic pulse_low;
      // longer than a marker half period, so it overlaps a released phase
      @(posedge sys_clk) pull_low <= 1'b1;
      repeat (8) @(posedge sys_clk);
      pull_low <= 1'b0;
   endtask
endmodule // mcu_model
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench of the config register bank
// Assumes: marker half period shortened to 4 clocks
// Notes: data line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module tb;
   import rcfg_pkg::*;
   logic sys_clk, rstn, frame_start, bit_valid, bit_value, pull_low, data_out, data_oe;
   logic poll_continuous, sleep_forever, off_cmd, write_done, reset_marker;
   oper_cfg_s oper_cfg;
   limit_cfg_s limit_cfg;
   logic [3:0] limit_scale, check_bits;
   logic [7:0] sleep_mult;
   logic [11:0] last_oper;
   int n_errors = 0, check_count = 0, n_wd = 0, n_off = 0, n_oe = 0;
   wire data_line = ~(data_oe | pull_low);
   receiver_config_registers #(
      .RM_HALF(4)
   ) i_receiver_config_registers (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .frame_start(frame_start),
      .bit_valid(bit_valid),
      .bit_value(bit_value),
      .data_in(data_line),
      .data_out(data_out),
      .data_oe(data_oe),
      .oper_cfg(oper_cfg),
      .limit_cfg(limit_cfg),
      .limit_scale(limit_scale),
      .check_bits(check_bits),
      .sleep_mult(sleep_mult),
      .poll_continuous(poll_continuous),
      .sleep_forever(sleep_forever),
      .off_cmd(off_cmd),
      .write_done(write_done),
      .reset_marker(reset_marker)
   );
   mcu_model i_mcu_model (
      .sys_clk(sys_clk),
      .frame_start(frame_start),
      .bit_valid(bit_valid),
      .bit_value(bit_value),
      .pull_low(pull_low)
   );
   always @(posedge sys_clk) begin
      if (write_done === 1'b1) n_wd <= n_wd + 1;
      if (off_cmd === 1'b1) n_off <= n_off + 1;
      if (data_oe === 1'b1) n_oe <= n_oe + 1;
   end
   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic frame(input logic [14:0] f, input int wd, input int off);
      int w0, o0;
      w0 = n_wd;
      o0 = n_off;
      i_mcu_model.send(f);
      repeat (4) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("write_done", 12'(wd), 12'(n_wd - w0));
      chk("off_cmd", 12'(off), 12'(n_off - o0));
   endtask
   task automatic t_reset;
      chk("oper", {2'h0, 2'h1, 1'b0, 5'h06, 1'b0, 1'b1}, oper_cfg);
      chk("limit", {6'h15, 6'h29}, limit_cfg);
      chk("scale", 12'h008, 12'(limit_scale));
      chk("checks", 12'h003, 12'(check_bits));
      chk("mult", 12'h001, 12'(sleep_mult));
      chk("poll", 12'h000, 12'(poll_continuous));
      chk("forever", 12'h000, 12'(sleep_forever));
      chk("marker", 12'h001, 12'(reset_marker));
      chk("data_oe", 12'h000, 12'(data_oe));
      chk("data_out", 12'h000, 12'(data_out));
   endtask
   task automatic t_marker;
      // own low phases have passed by now and must not have cancelled it
      @(negedge sys_clk);
      chk("marker", 12'h001, 12'(reset_marker));
      chk("marker drive", 12'h001, 12'(n_oe > 0));
      i_mcu_model.pulse_low;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("marker", 12'h000, 12'(reset_marker));
      chk("data_oe", 12'h000, 12'(data_oe));
   endtask
   task automatic t_oper;
      logic [4:0] s;
      for (int i = 0; i < 4; i++) begin
         s = (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'(i + 6);
         last_oper = {2'(i), 2'(i), 1'(i), s, 1'(i), 1'(~i)};
         frame({2'h1, last_oper, 1'b0}, 1, 0);
         chk("oper", last_oper, oper_cfg);
         chk("scale", 12'h008 >> i, 12'(limit_scale));
         chk("checks", 12'(3 * i), 12'(check_bits));
         chk("mult", (i % 2 == 1) ? 12'h008 : 12'h001, 12'(sleep_mult));
         chk("poll", 12'(i == 0), 12'(poll_continuous));
         chk("forever", 12'(i == 1), 12'(sleep_forever));
      end
   endtask
   task automatic t_limits;
      frame({2'h0, 6'h0a, 6'h3f, 1'b0}, 1, 0);
      chk("limit", {6'h0a, 6'h3f}, limit_cfg);
      chk("oper", last_oper, oper_cfg);
   endtask
   task automatic t_refused;
      frame({2'h1, 12'h000, 1'b1}, 0, 0);
      frame({2'h2, 12'h000, 1'b0}, 0, 1);
      frame({2'h3, 12'h000, 1'b0}, 0, 1);
      chk("oper", last_oper, oper_cfg);
      chk("limit", {6'h0a, 6'h3f}, limit_cfg);
   endtask
   task automatic print_verdict;
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   initial begin
      rstn = 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      @(negedge sys_clk);
      t_reset;
      repeat (20) @(posedge sys_clk);
      t_marker;
      t_oper;
      t_limits;
      t_refused;
      print_verdict;
   end
endmodule // tb
`default_nettype wire
